// ### pcdm_top.v
// secondary bus configuration visibility mask and idsel gating
`include "pcdm_map.vh"

module pcdm_top (
  input  wire                         i_clk_sys,
  input  wire                         i_reset_n,
  input  wire                         i_ce,
  input  wire                         i_reg_sel,
  input  wire                         i_reg_write,
  input  wire [7:0]                   i_reg_addr,
  input  wire [3:0]                   i_reg_be,
  input  wire [31:0]                  i_reg_wdata,
  output reg  [31:0]                  o_reg_rdata,
  output reg                          o_reg_ack,
  input  wire                         i_cyc_start,
  input  wire                         i_cyc_end,
  input  wire                         i_cyc_type0,
  input  wire [4:0]                   i_cyc_device,
  output reg  [`PCDM_IDSEL_WIDTH-1:0] o_idsel,
  output reg                          o_lan_decode_en,
  output reg                          o_cyc_hidden,
  output reg                          o_cyc_active,
  output reg  [`PCDM_CVM_WIDTH-1:0]   o_config_visibility_mask
);

  localparam [0:0] CYC_IDLE  = 1'b0;
  localparam [0:0] CYC_BUSY  = 1'b1;
  localparam [7:0] CVM_BYTE  = `PCDM_CVM_OFFSET;
  localparam [5:0] CVM_DWORD = CVM_BYTE[7:2];

  reg  [`PCDM_CVM_WIDTH-1:0]   config_visibility_mask;
  reg  [`PCDM_CVM_WIDTH-1:0]   next_mask;
  reg  [31:0]                  next_rdata;
  reg                          cyc_state;
  reg                          next_cyc_state;
  reg                          cyc_load;
  reg                          cyc_clear;
  wire [`PCDM_IDSEL_WIDTH-1:0] dec_idsel;
  wire                         dec_hidden;
  wire                         dec_lan;
  wire                         reg_hit;
  wire                         reg_wr;
  wire                         reg_rd;
  wire [`PCDM_CVM_WIDTH-1:0]   bit_wr;

  // byte lane enable that covers a given mask bit; be[3:2] never reach the register
  function lane_of;
    input [3:0] be;
    input integer b;
    begin
      lane_of = (b < 8) ? be[0] : be[1];
    end
  endfunction

  // whether a mask bit has a write path at all
  function writable;
    input integer b;
    reg [`PCDM_CVM_WIDTH-1:0] wm;
    begin
      wm = `PCDM_CVM_WR_MASK;
      writable = wm[b];
    end
  endfunction

  // dword decode; the register occupies the low half of dword 44h
  assign reg_hit = i_reg_sel & (i_reg_addr[7:2] == CVM_DWORD);
  assign reg_wr  = reg_hit & i_reg_write;
  assign reg_rd  = reg_hit & ~i_reg_write;

  genvar b;
  generate
    for (b = 0; b < `PCDM_CVM_WIDTH; b = b + 1) begin : g_bit
      if (writable(b)) begin : g_rw
        assign bit_wr[b] = reg_wr & lane_of(i_reg_be, b);
      end else begin : g_rsvd
        // reserved bits have no write path, so they always read back zero
        assign bit_wr[b] = 1'b0;
      end
    end
  endgenerate

  always @* begin
    next_mask = (config_visibility_mask & ~bit_wr)
              | (i_reg_wdata[15:0] & bit_wr);
  end

  always @* begin
    next_rdata = 32'h00000000;
    if (reg_rd) begin
      next_rdata = {16'h0000, config_visibility_mask};
    end
  end

  // cycle tracker: start wins over end on the same edge
  always @* begin
    next_cyc_state = cyc_state;
    cyc_load = 1'b0;
    cyc_clear = 1'b0;
    case (cyc_state)
      CYC_IDLE: begin
        if (i_cyc_start) begin
          next_cyc_state = CYC_BUSY;
          cyc_load = 1'b1;
        end
      end
      CYC_BUSY: begin
        if (i_cyc_start) begin
          cyc_load = 1'b1;
        end else if (i_cyc_end) begin
          next_cyc_state = CYC_IDLE;
          cyc_clear = 1'b1;
        end
      end
      default: begin
        next_cyc_state = CYC_IDLE;
      end
    endcase
  end

  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      config_visibility_mask <= `PCDM_CVM_RESET;
    end else if (i_ce) begin
      config_visibility_mask <= next_mask;
    end
  end

  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_config_visibility_mask <= `PCDM_CVM_RESET;
    end else if (i_ce) begin
      o_config_visibility_mask <= next_mask;
    end
  end

  // every access taken while i_ce is high is acknowledged, mapped or not, so software never hangs
  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_ack <= 1'b0;
    end else if (i_ce) begin
      o_reg_ack <= i_reg_sel;
    end
  end

  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata <= 32'h00000000;
    end else if (i_ce) begin
      o_reg_rdata <= next_rdata;
    end
  end

  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cyc_state <= CYC_IDLE;
    end else if (i_ce) begin
      cyc_state <= next_cyc_state;
    end
  end

  // decode uses the stored mask; a write landing on the start edge is not yet seen
  pcdm_idsel_dec u_dec (
    .i_device        (i_cyc_device),
    .i_type0         (i_cyc_type0),
    .i_mask          (config_visibility_mask),
    .o_idsel         (dec_idsel),
    .o_hidden        (dec_hidden),
    .o_lan_decode_en (dec_lan)
  );

  // outputs are captured at cycle start and held to its end, so a mid-cycle
  // write cannot tear a cycle already on the bus
  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_idsel <= {`PCDM_IDSEL_WIDTH{1'b0}};
    end else if (i_ce) begin
      if (cyc_load) begin
        o_idsel <= dec_idsel;
      end else if (cyc_clear) begin
        o_idsel <= {`PCDM_IDSEL_WIDTH{1'b0}};
      end
    end
  end

  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_lan_decode_en <= 1'b0;
    end else if (i_ce) begin
      if (cyc_load) begin
        o_lan_decode_en <= dec_lan;
      end else if (cyc_clear) begin
        o_lan_decode_en <= 1'b0;
      end
    end
  end

  // the hidden flag outlives the cycle so software can inspect the last attempt
  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_cyc_hidden <= 1'b0;
    end else if (i_ce) begin
      if (cyc_load) begin
        o_cyc_hidden <= dec_hidden;
      end
    end
  end

  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_cyc_active <= 1'b0;
    end else if (i_ce) begin
      o_cyc_active <= next_cyc_state;
    end
  end

endmodule

// ### pcdm_map.vh
// offsets, field positions, reset values and widths of the device masking logic
`ifndef PCDM_MAP_VH
`define PCDM_MAP_VH

`define PCDM_CVM_OFFSET     8'h44
`define PCDM_CVM_WIDTH      16
`define PCDM_CVM_RESET      16'h0000
`define PCDM_CVM_WR_MASK    16'h013F
`define PCDM_SLOT_COUNT     6
`define PCDM_LAN_BIT        8
`define PCDM_LAN_DEVICE     5'h08
`define PCDM_IDSEL_WIDTH    16
`define PCDM_IDSEL_BASE_AD  16

`endif

// ### pcdm_idsel_dec.v
// device number to idsel line decode with per-slot hiding
`include "pcdm_map.vh"

module pcdm_idsel_dec (
  input  wire [4:0]                   i_device,
  input  wire                         i_type0,
  input  wire [`PCDM_CVM_WIDTH-1:0]   i_mask,
  output wire [`PCDM_IDSEL_WIDTH-1:0] o_idsel,
  output wire                         o_hidden,
  output wire                         o_lan_decode_en
);

  wire [`PCDM_IDSEL_WIDTH-1:0] raw_sel;
  wire [`PCDM_IDSEL_WIDTH-1:0] kill;

  function hit;
    input [4:0] dev;
    input [4:0] n;
    begin
      hit = (dev == n);
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < `PCDM_IDSEL_WIDTH; g = g + 1) begin : g_line
      localparam [4:0] DEV_NUM = g;
      // line g carries idsel for device g, i.e. AD(16+g)
      assign raw_sel[g] = i_type0 & hit(i_device, DEV_NUM);
      if (g < `PCDM_SLOT_COUNT) begin : g_slot
        assign kill[g] = i_mask[g];
      end else begin : g_free
        // device 8 keeps its line: the lan hide acts on internal decode only
        assign kill[g] = 1'b0;
      end
    end
  endgenerate

  assign o_idsel = raw_sel & ~kill;
  assign o_hidden = |(raw_sel & kill);
  assign o_lan_decode_en = i_type0 & hit(i_device, `PCDM_LAN_DEVICE)
                           & ~i_mask[`PCDM_LAN_BIT];

endmodule

// ### pcdm_pci_devs.sv
// behavioural secondary bus devices answering config cycles
module pcdm_pci_devs (
  input  logic [15:0] i_idsel,
  input  logic        i_active,
  output logic [15:0] o_claim
);
  // a device answers only while its own line is high in a cycle
  assign o_claim = i_active ? i_idsel : 16'h0;
endmodule

// ### pcdm_chk.sv
// port assertions for the device masking block
module pcdm_chk (
  input logic        i_clk_sys, i_reset_n, i_ce, i_reg_sel, i_cyc_start, i_cyc_type0,
  input logic [4:0]  i_cyc_device,
  input logic [15:0] o_idsel, o_config_visibility_mask,
  input logic        o_lan_decode_en, o_cyc_hidden, o_reg_ack
);
  wire [15:0] m = o_config_visibility_mask;
  wire hit = i_cyc_device < 6 && m[i_cyc_device];
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  sequence go_s; i_ce && i_cyc_start && i_cyc_type0; endsequence
  sequence lan_s; go_s ##0 i_cyc_device == 8; endsequence
  slot_hide_a: assert property (go_s ##0 hit |=> o_idsel == 0 && o_cyc_hidden)
    else $error("hidden slot selected");
  slot_show_a: assert property (go_s ##0 !hit && i_cyc_device < 6 |=>
    o_idsel == 16'h1 << $past(i_cyc_device)) else $error("visible slot line");
  slot0_line_a: assert property (go_s ##0 !m[0] && i_cyc_device == 0 |=> o_idsel[0])
    else $error("slot 0 line");
  lan_mask_a: assert property (lan_s |=> o_lan_decode_en != $past(m[8]))
    else $error("lan decode");
  lan_bus_a: assert property (lan_s |=> o_idsel == 16'h0100) else $error("lan bus");
  mask_reset_a: assert property ($rose(i_reset_n) |-> m == 16'h0) else $error("rst");
  reg_ack_a: assert property (i_ce && i_reg_sel |=> o_reg_ack) else $error("ack");
  hold_cycle_a: assert property (!(i_ce && i_cyc_start) |=> $stable(o_cyc_hidden))
    else $error("hidden changed");
endmodule

// ### pcdm_top_tb.sv
// self-checking bench for the device masking block
module pcdm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic c = 0, r = 0, sel = 0, wr = 0, st = 0, en = 0, t0 = 0, ce = 1, ack, lan, hid, act;
  logic [4:0] dev = 0;
  logic [7:0] adr = 0;
  logic [15:0] ids, cpy, clm, m;
  logic [31:0] wd = 0, rd;
  int fail_count = 0, num_checks = 0, n = 0;
  pcdm_top dut (.i_clk_sys(c), .i_reset_n(r), .i_ce(ce), .i_reg_sel(sel), .i_reg_write(wr),
    .i_reg_addr(adr), .i_reg_be(4'h3), .i_reg_wdata(wd), .o_reg_rdata(rd), .o_reg_ack(ack),
    .i_cyc_start(st), .i_cyc_end(en), .i_cyc_type0(t0), .i_cyc_device(dev), .o_idsel(ids),
    .o_lan_decode_en(lan), .o_cyc_hidden(hid), .o_cyc_active(act),
    .o_config_visibility_mask(cpy));
  pcdm_pci_devs devs (.i_idsel(ids), .i_active(act), .o_claim(clm));
  initial forever #2 c = ~c;
  always @(posedge c) if (++n > 9000) begin fail_count++; test_done; end
  task test_done;
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(string s, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin fail_count++; $display("BAD %s exp %h got %h", s, e, g); end
  endtask
  task acc(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge c) #1 {sel, wr, adr, wd} = {1'b1, w, a, d};
    @(posedge c) #1 sel = 0;
    chk("ack", 1, ack);
  endtask
  task cfg(logic [4:0] d, logic t, logic mid);
    logic [15:0] e;
    logic h;
    h = t && d < 6 && m[d];
    e = t && !h ? 16'h1 << d : 16'h0;
    @(posedge c) #1 {st, dev, t0} = {1'b1, d, t};
    @(posedge c) #1 st = 0;
    chk("lan", t && d == 8 && !m[8], lan);
    chk("hidden", h, hid);
    if (mid) acc(1, 8'h44, ~m);
    if (mid) m = ~m & 16'h013F;
    chk("idsel", e, ids);
    chk("claim", e, clm);
    chk("copy", m, cpy);
    @(posedge c) #1 en = 1;
    @(posedge c) #1 en = 0;
  endtask
  initial begin
    void'($urandom(17));
    repeat (12) @(posedge c);
    #1 r = 1;
    acc(0, 8'h44, 0);
    chk("reset", 0, rd);
    acc(1, 8'h44, 32'hFFFF);
    acc(1, 8'h48, 0);
    acc(0, 8'h44, 0);
    chk("mask", 32'h013F, rd);
    m = 16'h013F;
    // a write offered while the clock enable is low must leave no trace
    @(posedge c) #1 {ce, sel, wr, adr, wd} = {1'b0, 1'b1, 1'b1, 8'h44, 32'h0};
    @(posedge c) #1 {ce, sel} = 2'b10;
    chk("frozen ack", 0, ack);
    // mid-cycle writes are the awkward case; hiding is meant for set-up only
    repeat (30) begin
      for (int d = 0; d < 9; d++) cfg(d, 1, 0);
      cfg($urandom, $urandom % 4 != 0, 1);
      m = $urandom & 16'h013F;
      acc(1, 8'h44, m);
    end
    test_done;
  end
endmodule
bind pcdm_top pcdm_chk chk (.*);
